/* hw/bcdh_pkg.sv */
// Constants, types and field layouts for the bit clear, debug halt and breakpoint unit
// Function
// - Test-and-clear samples the chosen bit for Z, then clears only that bit
// - Z set when sampled bit was zero; X, N, V and C untouched
// - Data register destination uses all 32 bits, bit number modulo 32
// - Memory destination is a byte read-modify-write, bit number modulo 8
// - Bit number zero always picks the least significant bit
// - Bit number comes from extension word or from a named data register
// - Dynamic form: top nibble zero, register 11..9, pattern 110, address 5..0
// - Static form: first word fixed in bits 15..6, address 5..0, extension upper byte zero, low byte number
// - Only data-alterable destinations accepted; others are illegal
// - Long size only for data register destination, byte otherwise
// - Halt with debug enabled suspends execution and raises halt acknowledge
// - Leaving debug state resumes at the current program counter
// - Halt without debug enable runs illegal-instruction exception stacking
// - Breakpoint cycle drives number on address 4..2, zeros on 1..0
// - Breakpoint cycle is a CPU-space access with type code zero
// - Normal acknowledge returns a word that is injected into the pipe
// - Acknowledge must move a full word; 8-bit port needs a second cycle
// - Bus error on the breakpoint cycle raises illegal-instruction exception
// - Breakpoint opcode holds a 3-bit number in bits 2..0
package bcdh_pkg;

  // Register map, byte addresses
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_STATUS    = 8'h04;
  localparam int          CTRL_HALT_EN  = 0;
  localparam int          CTRL_RESUME   = 1;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;

  // Opcode layouts
  localparam logic [3:0]  DYN_TOP       = 4'h0;
  localparam logic [2:0]  DYN_PATTERN   = 3'h6;
  localparam logic [9:0]  STAT_FIRST    = 10'h022;
  localparam logic [7:0]  STAT_EXT_HI   = 8'h00;
  localparam logic [12:0] SOFT_BREAKPOINT_OP_FIRST    = 13'h0909;

  // Addressing mode codes
  localparam logic [2:0]  MODE_DREG     = 3'h0;
  localparam logic [2:0]  MODE_AREG     = 3'h1;
  localparam logic [2:0]  MODE_EXT      = 3'h7;
  localparam logic [2:0]  EXT_ABS_W     = 3'h0;
  localparam logic [2:0]  EXT_ABS_L     = 3'h1;

  // Condition code positions
  localparam int          CCR_Z         = 2;

  // Bus sizes, function codes and acknowledge encodings
  localparam logic [1:0]  SZ_BYTE       = 2'h1;
  localparam logic [1:0]  SZ_WORD       = 2'h2;
  localparam logic [1:0]  SZ_LONG       = 2'h0;
  localparam logic [2:0]  FC_SUP_DATA   = 3'h5;
  localparam logic [2:0]  FC_CPU        = 3'h7;
  localparam logic [3:0]  CPU_TYPE_SOFT_BREAKPOINT_OP = 4'h0;
  localparam logic [1:0]  DSA_NONE      = 2'h0;
  localparam logic [1:0]  DSA_8         = 2'h1;

  // Exception stacking offsets
  localparam logic [31:0] OFS_FV        = 32'h0000_0002;
  localparam logic [31:0] OFS_PC        = 32'h0000_0006;
  localparam logic [31:0] OFS_SR        = 32'h0000_0008;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE, ST_MRD, ST_MWR, ST_HALT, ST_BPA, ST_BPB, ST_PFV, ST_PPC, ST_PSR, ST_VEC
  } bcdh_state_t;

  // Instruction issued by the core front end
  typedef struct packed {
    logic [15:0] op;
    logic [15:0] ext;
    logic [31:0] bitsrc;
    logic [31:0] dst;
    logic [31:0] ea;
    logic [31:0] pc;
    logic [15:0] sr;
    logic [31:0] supervisor_stack_pointer;
    logic [31:0] vbr;
  } bcdh_issue_t;

  // Operand bus request
  typedef struct packed {
    logic        req;
    logic        we;
    logic [1:0]  size;
    logic [2:0]  fc;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bcdh_mem_t;

endpackage

/* hw/bcdh_exec.sv */
// Execution unit for test-and-clear, debug halt and software breakpoint
//
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
module bcdh_exec
  import bcdh_pkg::*;
#(
  parameter logic [15:0] HALT_OPCODE = 16'h4afa,
  parameter logic [7:0]  ILL_VECTOR  = 8'h04
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        issue_valid,
  output logic             issue_ready,
  input  wire bcdh_issue_t issue,
  output bcdh_mem_t        mem,
  input  wire logic [1:0]  data_size_ack,
  input  wire logic        bus_error_in,
  input  wire logic [31:0] mem_rdata,
  output logic             done,
  output logic             reg_we,
  output logic      [31:0] reg_data,
  output logic             ccr_we,
  output logic      [4:0]  ccr,
  output logic             halt_ack,
  output logic             pipe_valid,
  output logic      [15:0] pipe_word,
  output logic             pc_load,
  output logic      [31:0] pc_value,
  output logic             ssp_we,
  output logic      [31:0] ssp_value
);

  bcdh_state_t state_ff;
  bcdh_issue_t iss_ff;
  bcdh_mem_t   mem_ff;
  logic        halt_en_ff;
  logic        resume_ff;
  logic        ack_ff;
  logic [31:0] rdat_ff;
  logic [2:0]  bitn_ff;
  logic [7:0]  bp_hi_ff;
  logic [2:0]  last_bp_ff;
  logic        last_bp_err_ff;
  logic        done_ff;
  logic        reg_we_ff;
  logic [31:0] reg_data_ff;
  logic        ccr_we_ff;
  logic [4:0]  ccr_ff;
  logic        pipe_vld_ff;
  logic [15:0] pipe_word_ff;
  logic        pc_ld_ff;
  logic [31:0] pc_ff;
  logic        ssp_we_ff;
  logic [31:0] ssp_ff;

  logic        is_dyn;
  logic        is_stat;
  logic        is_test_and_clear_bit_op;
  logic        is_halt;
  logic        is_soft_breakpoint_op;
  logic        ea_ok;
  logic        is_dreg;
  logic [31:0] bit_src;
  logic [4:0]  reg_idx;
  logic        reg_bit;
  logic [31:0] exp_reg;
  logic        take;
  logic        acked;
  logic        wb_req;
  logic [15:0] fv_word;

  // Opcode decoding for the two bit-number forms and the two debug opcodes
  assign is_dyn  = issue.op[15:12] == DYN_TOP && issue.op[8:6] == DYN_PATTERN;
  assign is_stat = issue.op[15:6] == STAT_FIRST && issue.ext[15:8] == STAT_EXT_HI;
  assign is_test_and_clear_bit_op = is_dyn || is_stat;
  assign is_halt = issue.op == HALT_OPCODE;
  assign is_soft_breakpoint_op = issue.op[15:3] == SOFT_BREAKPOINT_OP_FIRST;
  assign is_dreg = issue.op[5:3] == MODE_DREG;

  // Data-alterable destination check
  always_comb begin
    ea_ok = 1'b1;
    if (issue.op[5:3] == MODE_AREG) begin
      ea_ok = 1'b0;
    end else if (issue.op[5:3] == MODE_EXT) begin
      ea_ok = issue.op[2:0] == EXT_ABS_W || issue.op[2:0] == EXT_ABS_L;
    end
  end

  // Bit number source, register result and tested bit
  assign bit_src = is_dyn ? issue.bitsrc : {24'h0, issue.ext[7:0]};
  assign reg_idx = bit_src[4:0];
  assign reg_bit = issue.dst[reg_idx];
  assign exp_reg = issue.dst & ~(32'h1 << reg_idx);

  assign take        = ce && issue_valid && state_ff == ST_IDLE;
  assign acked       = data_size_ack != DSA_NONE;
  assign fv_word     = {4'h0, 2'h0, ILL_VECTOR, 2'h0};
  assign issue_ready = state_ff == ST_IDLE;
  assign wb_req      = wb_cyc_i && wb_stb_i && !ack_ff;

  // Build one operand bus request
  function automatic bcdh_mem_t mk_req(input logic we, input logic [1:0] sz,
                                       input logic [2:0] fc, input logic [31:0] addr,
                                       input logic [31:0] wdata);
    bcdh_mem_t r;
    r.req   = 1'b1;
    r.we    = we;
    r.size  = sz;
    r.fc    = fc;
    r.addr  = addr;
    r.wdata = wdata;
    return r;
  endfunction

  // Wishbone slave: one-cycle acknowledge, then dropped
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_ff     <= 1'b0;
      rdat_ff    <= 32'h0;
      halt_en_ff <= CTRL_RESET[CTRL_HALT_EN];
      resume_ff  <= 1'b0;
    end else if (ce) begin
      ack_ff    <= wb_req;
      resume_ff <= 1'b0;
      if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == REG_CTRL) begin
        halt_en_ff <= wb_dat_i[CTRL_HALT_EN];
        resume_ff  <= wb_dat_i[CTRL_RESUME];
      end
      if (wb_req && !wb_we_i) begin
        if (wb_adr_i == REG_CTRL) begin
          rdat_ff <= {31'h0, halt_en_ff};
        end else if (wb_adr_i == REG_STATUS) begin
          rdat_ff <= {23'h0, last_bp_err_ff, 1'b0, last_bp_ff, 2'h0,
                      state_ff != ST_IDLE, state_ff == ST_HALT};
        end else begin
          rdat_ff <= 32'h0;
        end
      end
    end
  end

  assign wb_dat_o = rdat_ff;
  assign wb_ack_o = ack_ff;

  // Instruction sequencer and operand bus
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff       <= ST_IDLE;
      iss_ff         <= '0;
      mem_ff         <= '0;
      bitn_ff        <= 3'h0;
      bp_hi_ff       <= 8'h0;
      last_bp_ff     <= 3'h0;
      last_bp_err_ff <= 1'b0;
      done_ff        <= 1'b0;
      reg_we_ff      <= 1'b0;
      reg_data_ff    <= 32'h0;
      ccr_we_ff      <= 1'b0;
      ccr_ff         <= 5'h0;
      pipe_vld_ff    <= 1'b0;
      pipe_word_ff   <= 16'h0;
      pc_ld_ff       <= 1'b0;
      pc_ff          <= 32'h0;
      ssp_we_ff      <= 1'b0;
      ssp_ff         <= 32'h0;
    end else if (ce) begin
      done_ff     <= 1'b0;
      reg_we_ff   <= 1'b0;
      ccr_we_ff   <= 1'b0;
      pipe_vld_ff <= 1'b0;
      pc_ld_ff    <= 1'b0;
      ssp_we_ff   <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (issue_valid) begin
            iss_ff <= issue;
            if (is_test_and_clear_bit_op && ea_ok && is_dreg) begin
              reg_data_ff <= exp_reg;
              reg_we_ff   <= 1'b1;
              ccr_ff      <= {issue.sr[4:3], !reg_bit, issue.sr[1:0]};
              ccr_we_ff   <= 1'b1;
              done_ff     <= 1'b1;
            end else if (is_test_and_clear_bit_op && ea_ok) begin
              bitn_ff  <= bit_src[2:0];
              mem_ff   <= mk_req(1'b0, SZ_BYTE, FC_SUP_DATA, issue.ea, 32'h0);
              state_ff <= ST_MRD;
            end else if (is_halt && halt_en_ff) begin
              state_ff <= ST_HALT;
            end else if (is_soft_breakpoint_op) begin
              last_bp_ff <= issue.op[2:0];
              mem_ff     <= mk_req(1'b0, SZ_WORD, FC_CPU,
                                   {12'h0, CPU_TYPE_SOFT_BREAKPOINT_OP, 11'h0, issue.op[2:0], 2'h0}, 32'h0);
              state_ff   <= ST_BPA;
            end else begin
              mem_ff   <= mk_req(1'b1, SZ_WORD, FC_SUP_DATA, issue.supervisor_stack_pointer - OFS_FV,
                                 {16'h0, fv_word});
              state_ff <= ST_PFV;
            end
          end
        end
        ST_MRD: begin
          if (bus_error_in) begin
            mem_ff   <= '0;
            done_ff  <= 1'b1;
            state_ff <= ST_IDLE;
          end else if (acked) begin
            ccr_ff   <= {iss_ff.sr[4:3], !mem_rdata[bitn_ff], iss_ff.sr[1:0]};
            mem_ff   <= mk_req(1'b1, SZ_BYTE, FC_SUP_DATA, iss_ff.ea,
                               {24'h0, mem_rdata[7:0] & ~(8'h1 << bitn_ff)});
            state_ff <= ST_MWR;
          end
        end
        ST_MWR: begin
          if (acked || bus_error_in) begin
            mem_ff    <= '0;
            ccr_we_ff <= acked;
            done_ff   <= 1'b1;
            state_ff  <= ST_IDLE;
          end
        end
        ST_HALT: begin
          if (resume_ff) begin
            done_ff  <= 1'b1;
            state_ff <= ST_IDLE;
          end
        end
        ST_BPA: begin
          if (bus_error_in) begin
            last_bp_err_ff <= 1'b1;
            mem_ff         <= mk_req(1'b1, SZ_WORD, FC_SUP_DATA, iss_ff.supervisor_stack_pointer - OFS_FV,
                                     {16'h0, fv_word});
            state_ff       <= ST_PFV;
          end else if (acked && data_size_ack == DSA_8) begin
            bp_hi_ff    <= mem_rdata[7:0];
            mem_ff.size <= SZ_BYTE;
            mem_ff.addr <= mem_ff.addr + 32'h1;
            state_ff    <= ST_BPB;
          end else if (acked) begin
            last_bp_err_ff <= 1'b0;
            mem_ff         <= '0;
            pipe_word_ff   <= mem_rdata[15:0];
            pipe_vld_ff    <= 1'b1;
            done_ff        <= 1'b1;
            state_ff       <= ST_IDLE;
          end
        end
        ST_BPB: begin
          if (bus_error_in) begin
            last_bp_err_ff <= 1'b1;
            mem_ff         <= mk_req(1'b1, SZ_WORD, FC_SUP_DATA, iss_ff.supervisor_stack_pointer - OFS_FV,
                                     {16'h0, fv_word});
            state_ff       <= ST_PFV;
          end else if (acked) begin
            last_bp_err_ff <= 1'b0;
            mem_ff         <= '0;
            pipe_word_ff   <= {bp_hi_ff, mem_rdata[7:0]};
            pipe_vld_ff    <= 1'b1;
            done_ff        <= 1'b1;
            state_ff       <= ST_IDLE;
          end
        end
        ST_PFV: begin
          if (acked) begin
            mem_ff   <= mk_req(1'b1, SZ_LONG, FC_SUP_DATA, iss_ff.supervisor_stack_pointer - OFS_PC, iss_ff.pc);
            state_ff <= ST_PPC;
          end
        end
        ST_PPC: begin
          if (acked) begin
            mem_ff   <= mk_req(1'b1, SZ_WORD, FC_SUP_DATA, iss_ff.supervisor_stack_pointer - OFS_SR,
                               {16'h0, iss_ff.sr});
            state_ff <= ST_PSR;
          end
        end
        ST_PSR: begin
          if (acked) begin
            mem_ff   <= mk_req(1'b0, SZ_LONG, FC_SUP_DATA,
                               iss_ff.vbr + {22'h0, ILL_VECTOR, 2'h0}, 32'h0);
            state_ff <= ST_VEC;
          end
        end
        ST_VEC: begin
          if (acked) begin
            mem_ff    <= '0;
            pc_ff     <= mem_rdata;
            pc_ld_ff  <= 1'b1;
            ssp_ff    <= iss_ff.supervisor_stack_pointer - OFS_SR;
            ssp_we_ff <= 1'b1;
            done_ff   <= 1'b1;
            state_ff  <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Output drive
  assign mem        = mem_ff;
  assign done       = done_ff;
  assign reg_we     = reg_we_ff;
  assign reg_data   = reg_data_ff;
  assign ccr_we     = ccr_we_ff;
  assign ccr        = ccr_ff;
  assign halt_ack   = state_ff == ST_HALT;
  assign pipe_valid = pipe_vld_ff;
  assign pipe_word  = pipe_word_ff;
  assign pc_load    = pc_ld_ff;
  assign pc_value   = pc_ff;
  assign ssp_we     = ssp_we_ff;
  assign ssp_value  = ssp_ff;

  // Checks on the sequencer
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_test_and_clear_bit_op_reg_result: assert property (take && is_test_and_clear_bit_op && ea_ok && is_dreg |=>
    reg_we_ff && reg_data_ff == $past(exp_reg)) else $error("register clear result wrong");
  a_test_and_clear_bit_op_zflag: assert property (take && is_test_and_clear_bit_op && ea_ok && is_dreg |=>
    ccr_ff[CCR_Z] == !$past(reg_bit)) else $error("zero flag wrong");
  a_ccr_keep_flags: assert property (ccr_we_ff |->
    ccr_ff[4:3] == iss_ff.sr[4:3] && ccr_ff[1:0] == iss_ff.sr[1:0])
    else $error("untouched flags changed");
  a_mem_byte_rmw: assert property (state_ff == ST_MRD && ce && acked && !bus_error_in |=>
    state_ff == ST_MWR && mem_ff.we && mem_ff.size == SZ_BYTE && mem_ff.wdata[bitn_ff] == 1'b0)
    else $error("memory clear write wrong");
  a_illegal_ea: assert property (take && is_test_and_clear_bit_op && !ea_ok |=> state_ff == ST_PFV)
    else $error("bad destination not trapped");
  a_halt_enter: assert property (take && is_halt && halt_en_ff |=> halt_ack ##1
    (halt_ack || $past(resume_ff))) else $error("halt acknowledge missing");
  a_bp_cycle_addr: assert property (state_ff == ST_BPA |-> mem_ff.req &&
    mem_ff.fc == FC_CPU && mem_ff.addr[4:2] == iss_ff.op[2:0] && mem_ff.addr[1:0] == 2'h0 &&
    mem_ff.addr[19:16] == CPU_TYPE_SOFT_BREAKPOINT_OP) else $error("breakpoint cycle address wrong");
  a_bp_byte_port: assert property (state_ff == ST_BPA && ce && data_size_ack == DSA_8 &&
    !bus_error_in |=> state_ff == ST_BPB && mem_ff.size == SZ_BYTE)
    else $error("second byte cycle missing");
  a_bp_error_trap: assert property (state_ff == ST_BPA && ce && bus_error_in |=>
    state_ff == ST_PFV ##[1:1000] pc_load) else $error("breakpoint error not trapped");
  a_debug_no_flags: assert property (state_ff inside {ST_HALT, ST_BPA, ST_BPB, ST_PFV,
    ST_PPC, ST_PSR, ST_VEC} |=> !ccr_we_ff) else $error("debug opcode changed flags");

  c_reg_clear: cover property (take && is_test_and_clear_bit_op && ea_ok && is_dreg ##1 reg_we_ff);
  c_mem_clear: cover property (state_ff == ST_MWR ##1 done_ff && ccr_we_ff);
  c_halt_resume: cover property (halt_ack ##[1:50] !halt_ack);
  c_bp_two_bytes: cover property (state_ff == ST_BPB ##1 pipe_valid);

endmodule // bcdh_exec

/* dv/bcdh_dbg_model.sv */
// Debug monitor and memory model on the far side of the operand bus
`timescale 1ns/1ps
module bcdh_dbg_model
  import bcdh_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire bcdh_mem_t   mem,
  input  wire logic [1:0]  bp_mode,
  input  wire logic [15:0] bp_word,
  input  wire logic        slow,
  output logic      [1:0]  data_size_ack,
  output logic             bus_error_in,
  output logic      [31:0] mem_rdata
);
  logic [7:0]  bytes [256];
  logic [31:0] cpu_addr;
  logic [2:0]  cpu_fc;
  logic [1:0]  wr_size;
  logic        busy;
  logic        waited;
  logic [31:0] rd;
  int          n;

  // Big-endian read of 1, 2 or 4 bytes
  always_comb begin
    n = (mem.size == SZ_BYTE) ? 1 : (mem.size == SZ_WORD) ? 2 : 4;
    rd = 32'h0;
    for (int i = 0; i < 4; i++)
      if (i < n) rd = {rd[23:0], bytes[mem.addr[7:0] + i[7:0]]};
  end

  // One answer per request; released lines flip so stale data never matches
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      data_size_ack <= 2'h0;
      bus_error_in  <= 1'b0;
      busy          <= 1'b0;
      waited        <= 1'b0;
      mem_rdata     <= 32'h0;
    end else if (busy) begin
      busy          <= 1'b0;
      data_size_ack <= 2'h0;
      bus_error_in  <= 1'b0;
      mem_rdata     <= ~mem_rdata;
    end else if (mem.req && slow && !waited) begin
      waited <= 1'b1;
    end else if (mem.req) begin
      busy   <= 1'b1;
      waited <= 1'b0;
      if (mem.fc == FC_CPU) begin
        if (!mem.addr[0]) cpu_addr <= mem.addr;
        cpu_fc <= mem.fc;
        if (bp_mode == 2'h2) begin
          bus_error_in <= 1'b1;
        end else if (bp_mode == 2'h1) begin
          data_size_ack <= DSA_8;
          mem_rdata     <= {24'h0, mem.addr[0] ? bp_word[7:0] : bp_word[15:8]};
        end else begin
          data_size_ack <= 2'h2;
          mem_rdata     <= {16'h0, bp_word};
        end
      end else begin
        data_size_ack <= 2'h3;
        mem_rdata     <= rd;
        if (mem.we) wr_size <= mem.size;
        for (int i = 0; i < 4; i++)
          if (mem.we && i < n) bytes[mem.addr[7:0] + i[7:0]] <= mem.wdata[8*(n-1-i) +: 8];
      end
    end
  end
endmodule // bcdh_dbg_model

/* dv/test_bit_clear_debug_halt_exec.sv */
// Self-checking bench for the test-and-clear, halt and breakpoint unit
`timescale 1ns/1ps
module test_bit_clear_debug_halt_exec
  import bcdh_pkg::*;
;
  localparam logic [7:0]  ILL  = 8'h04;
  localparam logic [31:0] PC0  = 32'h0000_0200;
  localparam logic [31:0] SSP0 = 32'h0000_0080;
  localparam logic [31:0] VBR0 = 32'h0000_0040;
  logic clk = 0, rstn = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, issue_valid = 0;
  logic [7:0] wb_adr_i = 8'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, mem_rdata, reg_data, pc_value, ssp_value, q;
  logic wb_ack_o, issue_ready, done, reg_we, ccr_we, halt_ack, pipe_valid, pc_load, ssp_we;
  logic bus_error_in, slow = 0, ce = 1;
  logic [3:0] wb_sel_i = 4'h0;
  logic [1:0] data_size_ack, bp_mode = 2'h0;
  logic [4:0] ccr, got_ccr;
  logic [15:0] pipe_word, got_pipe, bp_word = 16'h0, sr_in = 16'h001f;
  logic [31:0] got_reg, got_pc, got_ssp;
  bcdh_issue_t issue = '0;
  bcdh_mem_t   mem;
  int miscompares = 0, checks_done = 0, n_ccr = 0, n_exc = 0;

  bcdh_exec #(.ILL_VECTOR(ILL)) bcdh_exec_inst (.clk(clk), .rstn(rstn), .ce(ce),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .issue_valid(issue_valid), .issue_ready(issue_ready), .issue(issue), .mem(mem),
    .data_size_ack(data_size_ack), .bus_error_in(bus_error_in), .mem_rdata(mem_rdata),
    .done(done), .reg_we(reg_we), .reg_data(reg_data), .ccr_we(ccr_we), .ccr(ccr),
    .halt_ack(halt_ack), .pipe_valid(pipe_valid), .pipe_word(pipe_word),
    .pc_load(pc_load), .pc_value(pc_value), .ssp_we(ssp_we), .ssp_value(ssp_value));
  bcdh_dbg_model bcdh_dbg_model_inst (.clk(clk), .rstn(rstn), .mem(mem), .bp_mode(bp_mode),
    .bp_word(bp_word), .slow(slow), .data_size_ack(data_size_ack),
    .bus_error_in(bus_error_in), .mem_rdata(mem_rdata));

  // Clock and result capture
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (reg_we) got_reg <= reg_data;
    if (ccr_we) begin got_ccr <= ccr; n_ccr <= n_ccr + 1; end
    if (pipe_valid) got_pipe <= pipe_word;
    if (pc_load) begin got_pc <= pc_value; n_exc <= n_exc + 1; end
    if (ssp_we) got_ssp <= ssp_value;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [31:0] peek(input logic [7:0] a, input int n);
    peek = 32'h0;
    for (int i = 0; i < n; i++) peek = {peek[23:0], bcdh_dbg_model_inst.bytes[a + i[7:0]]};
  endfunction

  // Classic single Wishbone cycle, held until ack
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
    int k;
    @(posedge clk);
    wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we; wb_adr_i <= adr; wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    k = 0;
    do begin @(posedge clk); k++; end while (wb_ack_o !== 1'b1 && k < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
    if (k >= 20) miscompares++;
  endtask

  task automatic start(input logic [15:0] op, ext, input logic [31:0] bsrc, dst, ea);
    int k;
    @(posedge clk);
    issue <= '{op, ext, bsrc, dst, ea, PC0, sr_in, SSP0, VBR0};
    issue_valid <= 1'b1;
    k = 0;
    do begin @(posedge clk); k++; end while (issue_ready !== 1'b1 && k < 50);
    issue_valid <= 1'b0;
    if (k >= 50) miscompares++;
  endtask

  task automatic finish_op();
    int k;
    k = 0;
    do begin @(posedge clk); k++; end while (done !== 1'b1 && k < 200);
    @(posedge clk);
    if (k >= 200) miscompares++;
  endtask

  // Data register clears: modulo 32, bit 31, bit 0, both formats
  task automatic t_reg();
    logic [15:0] dyn, sta;
    dyn = {DYN_TOP, 3'h3, DYN_PATTERN, MODE_DREG, 3'h2};
    sta = {STAT_FIRST, MODE_DREG, 3'h1};
    start(dyn, 16'h0, 32'd33, 32'h8000_0002, 32'h0); finish_op();
    chk("reg mod32", 32'h8000_0000, got_reg);
    chk("ccr z0", 32'h1b, got_ccr);
    sr_in = 16'h0013;
    start(sta, {STAT_EXT_HI, 8'd31}, 32'h0, 32'h7fff_ffff, 32'h0); finish_op();
    chk("reg bit31", 32'h7fff_ffff, got_reg);
    chk("ccr z1", 32'h17, got_ccr);
    start(sta, {STAT_EXT_HI, 8'd0}, 32'h0, 32'h0000_0003, 32'h0); finish_op();
    chk("reg bit0", 32'h0000_0002, got_reg);
  endtask

  // Clock enable low: an offered clear must leave the captured register result untouched
  task automatic t_ce();
    ce <= 1'b0;
    start({STAT_FIRST, MODE_DREG, 3'h0}, {STAT_EXT_HI, 8'd4}, 0, 32'hffff_ffff, 0);
    repeat (4) @(posedge clk);
    chk("ce frozen", 32'h0000_0002, got_reg);
    ce <= 1'b1;
  endtask

  // Memory byte clears over every data-alterable mode
  task automatic t_mem();
    logic [5:0] eam [7];
    logic [7:0] a;
    eam = '{6'o20, 6'o31, 6'o42, 6'o53, 6'o64, 6'o70, 6'o71};
    sr_in = 16'h001f;
    for (int i = 0; i < 7; i++) begin
      a = 8'h20 + i[7:0];
      slow = i[0];
      bcdh_dbg_model_inst.bytes[a] = 8'h5a;
      if (i[0]) start({STAT_FIRST, eam[i]}, {STAT_EXT_HI, 8'd8 + i[7:0]}, 0, 0, {24'h0, a});
      else start({DYN_TOP, 3'h1, DYN_PATTERN, eam[i]}, 16'h0, 32'd16 + i, 0, {24'h0, a});
      finish_op();
      chk("mem byte", {24'h0, 8'h5a & ~(8'h1 << i)}, peek(a, 1));
      chk("mem ccr", {27'h0, 2'h3, 1'(~8'h5a >> i), 2'h3}, got_ccr);
      chk("mem size", {30'h0, SZ_BYTE}, {30'h0, bcdh_dbg_model_inst.wr_size});
    end
    slow = 1'b0;
  endtask

  // Illegal-instruction stacking and vector fetch
  task automatic exc_case(input logic [15:0] op);
    int e, c;
    e = n_exc;
    c = n_ccr;
    start(op, 16'h0, 0, 0, 0); finish_op();
    chk("exc count", e + 1, n_exc);
    chk("exc ccr", c, n_ccr);
    chk("exc pc", 32'h0012_2436, got_pc);
    chk("exc ssp", SSP0 - 8, got_ssp);
    chk("stack sr", {16'h0, sr_in}, peek(8'h78, 2));
    chk("stack pc", PC0, peek(8'h7a, 4));
    chk("stack fv", {22'h0, ILL, 2'h0}, peek(8'h7e, 2));
  endtask

  task automatic t_exc();
    for (int i = 0; i < 4; i++) bcdh_dbg_model_inst.bytes[VBR0[7:0] + 4 * ILL + i] = 8'h12 * i;
    exc_case({DYN_TOP, 3'h0, DYN_PATTERN, MODE_AREG, 3'h0});
    exc_case({STAT_FIRST, MODE_EXT, 3'h4});
    exc_case({STAT_FIRST, MODE_EXT, 3'h2});
    exc_case(16'h4afa);
  endtask

  // Debug halt entry, status, resume
  task automatic t_halt();
    int e, c;
    e = n_exc;
    c = n_ccr;
    wb(1'b1, REG_CTRL, 32'h1);
    start(16'h4afa, 16'h0, 0, 0, 0);
    repeat (3) @(posedge clk);
    chk("halt ack", 32'h1, {31'h0, halt_ack});
    wb(1'b0, REG_STATUS, 32'h0);
    chk("status halted", 32'h1, q & 32'h1);
    wb(1'b1, REG_CTRL, 32'h3);
    finish_op();
    chk("halt left", 32'h0, {31'h0, halt_ack});
    chk("resume no vector", e, n_exc);
    chk("halt ccr", c, n_ccr);
    wb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl read", 32'h1, q);
    wb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h0, q);
  endtask

  // Breakpoint acknowledge: word port, byte port, bus error
  task automatic t_soft_breakpoint_op();
    logic [2:0] num [3];
    int c;
    num = '{3'h5, 3'h7, 3'h3};
    for (int i = 0; i < 3; i++) begin
      bp_mode = i[1:0];
      slow = i[0];
      bp_word = 16'h4e71 + 16'h1111 * i;
      c = n_ccr;
      if (i == 2) begin
        exc_case({SOFT_BREAKPOINT_OP_FIRST, num[i]});
      end else begin
        start({SOFT_BREAKPOINT_OP_FIRST, num[i]}, 16'h0, 0, 0, 0); finish_op();
        chk("pipe word", {16'h0, bp_word}, {16'h0, got_pipe});
        chk("bp ccr", c, n_ccr);
      end
      chk("bp addr", {12'h0, CPU_TYPE_SOFT_BREAKPOINT_OP, 11'h0, num[i], 2'h0},
          bcdh_dbg_model_inst.cpu_addr);
      chk("bp fc", {29'h0, FC_CPU}, {29'h0, bcdh_dbg_model_inst.cpu_fc});
    end
    wb(1'b0, REG_STATUS, 32'h0);
    chk("status bp", 32'h130, q & 32'h170);
  endtask

  // Watchdog
  initial begin
    #200us;
    miscompares++;
    conclude();
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_reg();
    t_ce();
    t_mem();
    t_exc();
    t_halt();
    t_soft_breakpoint_op();
    conclude();
  end
endmodule // test_bit_clear_debug_halt_exec
